/* File: inc/gei_pkg.sv */
/*
  Package for the pin edge interrupt block: register offsets, field
  positions, reset values and the register request carrier.
  Assumes an 8-bit register port driven by the serial interface slave.
*/
package gei_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned GEI_PINS = 16;
  localparam int unsigned GEI_DW   = 8;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] GEI_OFS_STATUS_LOW  = 8'hb1;
  localparam logic [7:0] GEI_OFS_STATUS_HIGH = 8'hb2;
  localparam logic [7:0] GEI_OFS_MASK_LOW    = 8'hb4;
  localparam logic [7:0] GEI_OFS_MASK_HIGH   = 8'hb5;
  localparam logic [7:0] GEI_OFS_EDGE_A      = 8'hc0;
  localparam logic [7:0] GEI_OFS_EDGE_B      = 8'hc1;
  localparam logic [7:0] GEI_OFS_EDGE_C      = 8'hc2;
  localparam logic [7:0] GEI_OFS_EDGE_D      = 8'hc3;
  localparam logic [7:0] GEI_OFS_CONTROL     = 8'hc5;
  localparam logic [7:0] GEI_OFS_CLEAR_ALL   = 8'hc7;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned GEI_CTL_CLR_ON_READ = 2;
  localparam int unsigned GEI_CTL_PEND_DIS    = 1;
  localparam int unsigned GEI_EDGE_RISE       = 1;
  localparam int unsigned GEI_EDGE_FALL       = 0;

  // Pins that exist: 0..5, 9, 10, 11, 12, 14
  localparam logic [15:0] GEI_PIN_VALID     = 16'h5e3f;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] GEI_RST_MASK      = 8'hff;
  localparam logic [7:0] GEI_RST_EDGE      = 8'h00;
  localparam logic [7:0] GEI_RST_STATUS    = 8'h00;
  localparam logic [7:0] GEI_RST_CONTROL   = 8'h01;
  localparam logic [7:0] GEI_CTL_WR_BITS   = 8'h07;
  localparam logic [7:0] GEI_RDATA_IDLE    = 8'h00;

  // ----------------------------------------------------------------
  // Register request carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gei_reg_req_t;

endpackage

/* File: hw/gei_edge_detect.sv */
/*
  One-pin edge detector with rise and fall enables.
  Assumes the pin input is already synchronous to core_clk.
*/
`timescale 1ns/1ps
module gei_edge_detect
  import gei_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       pin,
  input  wire logic [1:0] edge_sel,
  output logic            event_pulse
);

  logic prev_q;
  logic primed_q;

  // ----------------------------------------------------------------
  // Previous sample; no event until one sample has been taken
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      prev_q   <= 1'b0;
      primed_q <= 1'b0;
    end
    else
    begin
      prev_q   <= pin;
      primed_q <= 1'b1;
    end
  end

  // 01 fall, 10 rise, 11 both, 00 off
  assign event_pulse = primed_q &
    ((edge_sel[GEI_EDGE_RISE] & pin & ~prev_q) |
     (edge_sel[GEI_EDGE_FALL] & ~pin & prev_q));

endmodule // gei_edge_detect

/* File: hw/gei_status_bank.sv */
/*
  Eight sticky status bits: hardware sets, register logic clears.
  Assumes set and clear arrive as one-cycle vectors on core_clk.
*/
`timescale 1ns/1ps
module gei_status_bank
  import gei_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic [7:0] set_bits,
  input  wire logic [7:0] clr_bits,
  output logic [7:0]      status_q
);

  // ----------------------------------------------------------------
  // Sticky bits, set wins over clear in the same cycle
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
      status_q <= GEI_RST_STATUS;
    else
      status_q <= (status_q & ~clr_bits) | set_bits;
  end

endmodule // gei_status_bank

/* File: hw/gei_ctrl.sv */
/*
  Pin edge interrupt controller: edge selection, masks, status and
  the active-low request line, reached over an 8-bit register port.
  Assumes the serial interface slave presents one-cycle rd/wr strobes
  in the core_clk domain and takes read data one cycle later.
*/
// Functional notes
// - Upper status: pin14 bit6, pin12 bit4, pins 11,10,9 bits 3,2,1.
// - Mask bit 1 blocks the pin event from the request line.
// - All mask bits, reserved too, reset to 1.
// - Mask writes are taken on the interface clock; here they are taken on core_clk.
// - Lower mask holds pins 0 to 5 at bits 0 to 5.
// - Upper mask: pin14 bit6, pin12 bit4, pins 11,10,9 bits 3,2,1.
// - Edge field: 01 fall, 10 rise, 11 both, 00 off.
// - First edge register: pin n at bits 2n+1:2n, rise high bit.
// - Second edge register: pin4 bits 1:0, pin5 bits 3:2.
// - Third edge register: pins 9, 10, 11 at bits 3:2, 5:4, 7:6.
// - Fourth edge register: pin12 bits 1:0, pin14 bits 5:4.
// - All edge enables reset to 0.
// - Pending disabled drops events arriving while the line is active.
// - Clear-on-read: reading a status register clears it.
// - Without clear-on-read, clear-all address clears every status.
// - Clear mode bit: 0 write clears, 1 read clears; resets 0.
// - Writing 1 never sets status; writes ignored in clear-on-read.
// - Pending-event disable bit resets 0; writing 1 disables.
`timescale 1ns/1ps
module gei_ctrl
  import gei_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic [15:0]  pin_in,
  input  wire gei_reg_req_t reg_req,
  output logic [7:0]        reg_rdata,
  output logic              pin_irq_line_one_n
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]  pin_irq_mask_low_q;
  logic [7:0]  pin_irq_mask_high_q;
  logic [7:0]  pin_edge_select_a_q;
  logic [7:0]  pin_edge_select_b_q;
  logic [7:0]  pin_edge_select_c_q;
  logic [7:0]  pin_edge_select_d_q;
  logic [7:0]  irq_handler_control_q;
  logic [7:0]  rdata_q;
  logic [7:0]  status_low;
  logic [7:0]  pin_irq_status_high;
  logic [31:0] edge_fields;
  logic [15:0] mask_all;
  logic [15:0] status_all;
  logic [15:0] pin_event;
  logic [15:0] set_all;
  logic [7:0]  clr_low;
  logic [7:0]  clr_high;
  logic        clear_on_read_select;
  logic        pending_event_disable;
  logic        line_active;
  logic        accept_event;
  logic        hit_clear_all;

  // ----------------------------------------------------------------
  // Write side
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pin_irq_mask_low_q  <= GEI_RST_MASK;
      pin_irq_mask_high_q <= GEI_RST_MASK;
    end
    else if (reg_req.wr)
    begin
      if (reg_req.addr == GEI_OFS_MASK_LOW)
        pin_irq_mask_low_q <= reg_req.wdata;
      if (reg_req.addr == GEI_OFS_MASK_HIGH)
        pin_irq_mask_high_q <= reg_req.wdata;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pin_edge_select_a_q <= GEI_RST_EDGE;
      pin_edge_select_b_q <= GEI_RST_EDGE;
      pin_edge_select_c_q <= GEI_RST_EDGE;
      pin_edge_select_d_q <= GEI_RST_EDGE;
    end
    else if (reg_req.wr)
    begin
      case (reg_req.addr)
        GEI_OFS_EDGE_A: pin_edge_select_a_q <= reg_req.wdata;
        GEI_OFS_EDGE_B: pin_edge_select_b_q <= reg_req.wdata;
        GEI_OFS_EDGE_C: pin_edge_select_c_q <= reg_req.wdata;
        GEI_OFS_EDGE_D: pin_edge_select_d_q <= reg_req.wdata;
        default: ;
      endcase
    end
  end

  // Bits 7:3 read as zero; the rest are writable
  always_ff @(posedge core_clk)
  begin
    if (rst)
      irq_handler_control_q <= GEI_RST_CONTROL;
    else if (reg_req.wr && reg_req.addr == GEI_OFS_CONTROL)
      irq_handler_control_q <= reg_req.wdata & GEI_CTL_WR_BITS;
  end

  assign clear_on_read_select  =
    irq_handler_control_q[GEI_CTL_CLR_ON_READ];
  assign pending_event_disable =
    irq_handler_control_q[GEI_CTL_PEND_DIS];

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  // Fields line up as pin n at bits 2n+1:2n across the four registers
  assign edge_fields = {pin_edge_select_d_q,
                        pin_edge_select_c_q,
                        pin_edge_select_b_q,
                        pin_edge_select_a_q};

  for (genvar p = 0; p < GEI_PINS; p++)
  begin : g_pin
    gei_edge_detect u_edge (
      .core_clk    (core_clk),
      .rst         (rst),
      .pin         (pin_in[p]),
      .edge_sel    (edge_fields[2*p+1:2*p]),
      .event_pulse (pin_event[p])
    );
  end

  // ----------------------------------------------------------------
  // Status setting and clearing
  // ----------------------------------------------------------------
  assign mask_all    = {pin_irq_mask_high_q, pin_irq_mask_low_q};
  assign status_all  = {pin_irq_status_high, status_low};
  assign line_active = |(status_all & ~mask_all & GEI_PIN_VALID);
  assign accept_event = ~(pending_event_disable & line_active);

  // Masked and reserved pins never set status
  assign set_all = pin_event & ~mask_all & GEI_PIN_VALID
                   & {GEI_PINS{accept_event}};

  assign hit_clear_all = ~clear_on_read_select &
                         (reg_req.rd | reg_req.wr) &
                         (reg_req.addr == GEI_OFS_CLEAR_ALL);

  always_comb
  begin
    clr_low  = 8'h00;
    clr_high = 8'h00;
    if (hit_clear_all)
    begin
      clr_low  = 8'hff;
      clr_high = 8'hff;
    end
    else if (clear_on_read_select)
    begin
      if (reg_req.rd && reg_req.addr == GEI_OFS_STATUS_LOW)
        clr_low = 8'hff;
      if (reg_req.rd && reg_req.addr == GEI_OFS_STATUS_HIGH)
        clr_high = 8'hff;
    end
    else if (reg_req.wr)
    begin
      // Ones clear; zeros and clear-on-read writes change nothing
      if (reg_req.addr == GEI_OFS_STATUS_LOW)
        clr_low = reg_req.wdata;
      if (reg_req.addr == GEI_OFS_STATUS_HIGH)
        clr_high = reg_req.wdata;
    end
  end

  gei_status_bank u_status_low (
    .core_clk (core_clk),
    .rst      (rst),
    .set_bits (set_all[7:0]),
    .clr_bits (clr_low),
    .status_q (status_low)
  );

  // Bit k reports pin 8+k
  gei_status_bank u_status_high (
    .core_clk (core_clk),
    .rst      (rst),
    .set_bits (set_all[15:8]),
    .clr_bits (clr_high),
    .status_q (pin_irq_status_high)
  );

  // ----------------------------------------------------------------
  // Read side
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
      rdata_q <= GEI_RDATA_IDLE;
    else if (reg_req.rd)
    begin
      case (reg_req.addr)
        GEI_OFS_STATUS_LOW:  rdata_q <= status_low;
        GEI_OFS_STATUS_HIGH: rdata_q <= pin_irq_status_high;
        GEI_OFS_MASK_LOW:    rdata_q <= pin_irq_mask_low_q;
        GEI_OFS_MASK_HIGH:   rdata_q <= pin_irq_mask_high_q;
        GEI_OFS_EDGE_A:      rdata_q <= pin_edge_select_a_q;
        GEI_OFS_EDGE_B:      rdata_q <= pin_edge_select_b_q;
        GEI_OFS_EDGE_C:      rdata_q <= pin_edge_select_c_q;
        GEI_OFS_EDGE_D:      rdata_q <= pin_edge_select_d_q;
        GEI_OFS_CONTROL:     rdata_q <= irq_handler_control_q;
        default:             rdata_q <= GEI_RDATA_IDLE;
      endcase
    end
  end

  assign reg_rdata = rdata_q;

  // ----------------------------------------------------------------
  // Request line
  // ----------------------------------------------------------------
  assign pin_irq_line_one_n = ~line_active;

endmodule // gei_ctrl

/* File: testbench/gei_chk_chk.sv */
/*
  Checker for the pin edge interrupt controller ports.
  Assumes it is bound to gei_ctrl and sees only that module's ports.
*/
`timescale 1ns/1ps
module gei_chk
  import gei_pkg::*;
(
  input wire logic         core_clk,
  input wire logic         rst,
  input wire logic [15:0]  pin_in,
  input wire gei_reg_req_t reg_req,
  input wire logic [7:0]   reg_rdata,
  input wire logic         pin_irq_line_one_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_cfg_wr;
    reg_req.wr && reg_req.addr inside {8'hb4, 8'hb5, [8'hc0:8'hc3]};
  endsequence
  sequence s_gap_rd;
    !reg_req.wr && !reg_req.rd ##1
    reg_req.rd && !reg_req.wr && reg_req.addr == $past(reg_req.addr, 2);
  endsequence
  AST_RST_IDLE: assert property (
    $fell(rst) |-> pin_irq_line_one_n && reg_rdata == 8'h00)
    else $error("line or read data not idle after reset");
  AST_RDATA_HOLD: assert property (
    !$past(reg_req.rd) && !$past(rst) |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  AST_CTL_RSVD: assert property (
    reg_req.rd && reg_req.addr == 8'hc5 |=> reg_rdata[7:3] == 5'h00)
    else $error("control upper bits not zero");
  AST_CFG_READBACK: assert property (
    s_cfg_wr ##1 s_gap_rd |=> reg_rdata == $past(reg_req.wdata, 3))
    else $error("configuration readback differs");
  AST_STAT_HIGH_RSVD: assert property (
    reg_req.rd && reg_req.addr == 8'hb2 |=> (reg_rdata & 8'ha1) == 8'h00)
    else $error("upper status reserved bit set");
  AST_STAT_LOW_RSVD: assert property (
    reg_req.rd && reg_req.addr == 8'hb1 |=> reg_rdata[7:6] == 2'b00)
    else $error("lower status reserved bit set");
  AST_LINE_FALL: assert property (
    $fell(pin_irq_line_one_n) |->
    $past(pin_in) != $past(pin_in, 2) || $past(reg_req.wr))
    else $error("line fell without pin change or write");
  AST_LINE_RISE: assert property (
    $rose(pin_irq_line_one_n) && !$past(rst) |->
    ($past(reg_req.rd) || $past(reg_req.wr)) &&
    $past(reg_req.addr) inside {8'hb1, 8'hb2, 8'hb4, 8'hb5, 8'hc7})
    else $error("line released without status or mask access");
endmodule // gei_chk

/* File: testbench/gei_host_model.sv */
/*
  Host model: single-byte register reads and writes on the port.
  Assumes callers enter the task just after a rising clock edge.
*/
`timescale 1ns/1ps
module gei_host_model
  import gei_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic [7:0] reg_rdata,
  output gei_reg_req_t    reg_req
);
  initial reg_req = '0;
  task automatic access(input logic w, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    reg_req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge core_clk);
    // Released bus shows inverted values, never the stale ones
    reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    @(posedge core_clk);
    q = reg_rdata;
  endtask
endmodule // gei_host_model

/* File: testbench/testbench.sv */
/*
  Self-checking bench for gei_ctrl: host model on the register port,
  pins driven here. Assumes the checker is bound below the module.
*/
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("unexpected at %0t: got %h exp %h", $time, got, exp); \
    end \
  end
module testbench
  import gei_pkg::*;
;
  logic         core_clk;
  logic         rst;
  logic [15:0]  pin_in;
  gei_reg_req_t reg_req;
  logic [7:0]   reg_rdata;
  logic         pin_irq_line_one_n;
  logic [7:0]   q;
  logic [7:0]   d;
  int           fails;
  int           comparisons;
  int           seed;
  int           p;
  int           pins [11] = '{0, 1, 2, 3, 4, 5, 9, 10, 11, 12, 14};
  logic [7:0]   adr [7]   = '{8'hb4, 8'hb5, 8'hc0, 8'hc1, 8'hc2, 8'hc3, 8'hc5};
  logic [7:0]   rv [7]    = '{8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};

  gei_host_model host (.core_clk(core_clk), .reg_rdata(reg_rdata),
                       .reg_req(reg_req));
  gei_ctrl dut (.core_clk(core_clk), .rst(rst), .pin_in(pin_in),
                .reg_req(reg_req), .reg_rdata(reg_rdata),
                .pin_irq_line_one_n(pin_irq_line_one_n));

  function automatic logic [7:0] edge_addr(int n);
    return n < 4 ? 8'hc0 : n < 8 ? 8'hc1 : n < 12 ? 8'hc2 : 8'hc3;
  endfunction
  function automatic logic hit(int m, logic up);
    return m < 4 && (up ? m[1] : m[0]);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    host.access(1'b1, a, v, q);
  endtask
  task automatic rd(input logic [7:0] a);
    host.access(1'b0, a, 8'h00, q);
  endtask
  task automatic drive(int n, logic v);
    pin_in[n] <= v;
    // Noise on absent pins
    pin_in[15] <= 1'($random(seed));
    pin_in[7] <= 1'($random(seed));
    repeat (2) @(posedge core_clk);
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
  endtask
  task automatic test_done();
    if (fails == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // About 1000 cycles expected; twenty times that is a hang
  initial
  begin
    #400000;
    fails++;
    test_done();
  end
  initial
  begin
    rst = 1'b1;
    pin_in = 16'h0000;
    seed = 32'hc876;
    fails = 0;
    comparisons = 0;
    do_reset();
    for (int i = 0; i < 7; i++)
    begin
      rd(adr[i]);
      `CHK(q, rv[i])
    end
    for (int i = 0; i < 6; i++)
    begin
      d = 8'($random(seed));
      wr(adr[i], d);
      rd(adr[i]);
      `CHK(q, d)
      wr(adr[i], rv[i]);
    end
    foreach (pins[i])
      for (int m = 0; m < 5; m++)
      begin
        p = pins[i];
        wr(edge_addr(p), 8'(m == 4 ? 3 : m) << (2 * (p % 4)));
        wr(p < 8 ? 8'hb4 : 8'hb5, m == 4 ? 8'hff : ~(8'h01 << (p % 8)));
        drive(p, 1'b1);
        `CHK(pin_irq_line_one_n, !hit(m, 1'b1))
        rd(p < 8 ? 8'hb1 : 8'hb2);
        `CHK(q[p % 8], hit(m, 1'b1))
        wr(p < 8 ? 8'hb1 : 8'hb2, 8'hff);
        drive(p, 1'b0);
        `CHK(pin_irq_line_one_n, !hit(m, 1'b0))
        rd(p < 8 ? 8'hb1 : 8'hb2);
        `CHK(q[p % 8], hit(m, 1'b0))
        wr(p < 8 ? 8'hb1 : 8'hb2, 8'hff);
      end
    // Upper control bits written as ones must read back as zero
    wr(8'hc5, 8'hfd);
    rd(8'hc5);
    `CHK(q, 8'h05)
    wr(8'hc3, 8'h20);
    wr(8'hb5, 8'hbf);
    drive(14, 1'b1);
    wr(8'hb2, 8'h00);
    `CHK(pin_irq_line_one_n, 1'b0)
    rd(8'hb2);
    `CHK(q, 8'h40)
    `CHK(pin_irq_line_one_n, 1'b1)
    rd(8'hb2);
    `CHK(q, 8'h00)
    wr(8'hc5, 8'h01);
    drive(14, 1'b0);
    drive(14, 1'b1);
    rd(8'hc7);
    `CHK(pin_irq_line_one_n, 1'b1)
    rd(8'hb2);
    `CHK(q, 8'h00)
    wr(8'hc2, 8'h0c);
    // Absent pin 15 gets both edges and no mask: it must stay silent
    wr(8'hc3, 8'hc3);
    wr(8'hb5, 8'h6d);
    for (int pd = 0; pd < 2; pd++)
    begin
      wr(8'hc5, pd == 1 ? 8'h03 : 8'h01);
      drive(9, !pin_in[9]);
      drive(12, !pin_in[12]);
      rd(8'hb2);
      `CHK(q, pd == 1 ? 8'h02 : 8'h12)
      // Clear-all by read first, then by write
      host.access(pd == 1, 8'hc7, 8'h00, q);
    end
    `CHK(pin_irq_line_one_n, 1'b1)
    do_reset();
    rd(8'hb5);
    `CHK(q, 8'hff)
    rd(8'hc5);
    `CHK(q, 8'h01)
    test_done();
  end
endmodule // testbench

bind gei_ctrl gei_chk u_chk (
  .core_clk(core_clk), .rst(rst), .pin_in(pin_in), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .pin_irq_line_one_n(pin_irq_line_one_n));
